// ---- rtl/svwd_pkg.sv ----
// Shared constants and types for the supervisor event logic
`default_nettype none
package svwd_pkg;
  // Clock and timing figures
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned FILTER_NS = 2000;
  localparam int unsigned FILTER_CYC = FILTER_NS / CLK_PERIOD_NS;
  localparam int unsigned ALARM_MIN_NS = 10000;
  localparam int unsigned ALARM_MIN_CYC =
    (ALARM_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEBOUNCE_NS = 20000;
  localparam int unsigned DEBOUNCE_CYC =
    (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WD_PULSE_NS = 100000;
  localparam int unsigned WD_PULSE_CYC =
    (WD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint unsigned NS_PER_MS = 1000000;
  localparam longint unsigned PERIOD_SHORT_MS = 10;
  localparam longint unsigned PERIOD_MID_MS = 100;
  localparam longint unsigned PERIOD_LONG_MS = 1000;
  localparam int unsigned SHORT_CYC =
    int'(PERIOD_SHORT_MS * NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned MID_CYC =
    int'(PERIOD_MID_MS * NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned LONG_CYC =
    int'(PERIOD_LONG_MS * NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned CNT_W = 25;
  localparam int unsigned SMALL_W = 12;

  // Three-level strap codes
  localparam logic [1:0] SEL_GROUND = 2'h0;
  localparam logic [1:0] SEL_FLOAT = 2'h1;
  localparam logic [1:0] SEL_SUPPLY = 2'h2;

  // Register map, byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_EVENT = 8'h04;

  // Event bit positions
  localparam int unsigned EV_MASTER = 0;
  localparam int unsigned EV_ALARM1 = 1;
  localparam int unsigned EV_ALARM2 = 2;
  localparam int unsigned EV_WDOG = 3;
  localparam int unsigned EV_W = 4;
  localparam logic [EV_W-1:0] EV_RESET = 4'h0;

  // Watchdog states
  typedef enum logic [2:0] {
    WD_IDLE = 3'b001,
    WD_COUNT = 3'b010,
    WD_PULSE = 3'b100
  } svwd_wd_state_t;

  // Status word, low bits of the status register
  typedef struct packed {
    logic [1:0] wd_select;
    logic hold_all;
    logic supply_rst_b;
    logic supply_rst_a;
    logic wd_pulse;
    logic alarm_two;
    logic alarm_one;
    logic flag_low;
  } svwd_status_t;
endpackage
`default_nettype wire

// ---- rtl/svwd_sync.sv ----
// Three-stage pin synchroniser with agreement check
`default_nettype none
module svwd_sync
  import svwd_pkg::*;
#(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pin_i,
  output var logic [W-1:0] value_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // Only the second stage reads the first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A bit changes once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      value_o <= INIT;
    else
      value_o <= (s2_r & s3_r) | (value_o & (s2_r ^ s3_r));
  end
endmodule
`default_nettype wire

// ---- rtl/svwd_alarm.sv ----
// Sense alarm: dip filter, forcing and minimum active time
`default_nettype none
module svwd_alarm
  import svwd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic below_i,
  input wire logic force_i,
  output var logic alarm_o
);
  logic [SMALL_W-1:0] filt_r;
  logic [SMALL_W-1:0] hold_r;
  logic filt_done;

  assign filt_done = (filt_r == SMALL_W'(FILTER_CYC));

  // Dips shorter than the filter time never reach the output
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !below_i)
      filt_r <= '0;
    else if (!filt_done)
      filt_r <= filt_r + SMALL_W'(1);
  end

  // Stretch keeps the pin low long enough for a slow handler
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      alarm_o <= 1'b1;
      hold_r <= '0;
    end
    else if (force_i || filt_done)
    begin
      alarm_o <= 1'b1;
      hold_r <= '0;
    end
    else if (alarm_o)
    begin
      if (hold_r >= SMALL_W'(ALARM_MIN_CYC - 1))
        alarm_o <= 1'b0;
      else
        hold_r <= hold_r + SMALL_W'(1);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/svwd_top.sv ----
// Supervisor event logic: reset source flag, sense alarms, watchdog
// Notes on behaviour
// - Master manual reset drives the reset-source flag low and holds it.
// - Flag releases only on a reset from a source other than master.
// - Once released, flag stays high until the next master reset.
// - Flag pin is open drain; it only sinks, a pull-up makes high.
// - Outputs stay valid while any supply is at least 1.0V.
// - Below 1.5V on both main supplies, every output is held active.
// - Sense alarm goes low for at least 10 us on a trip.
// - Sense input must stay below trip about 2 us; shorter dips ignored.
// - Alarm sinks while sense is below reference, releases above it.
// - At power-up alarms stay active until a main supply reaches 1.5V.
// - Watchdog alarm fires when strobe shows no edge within timeout.
// - Period select: ground 10 ms, float 100 ms, supply 1000 ms.
// - Watchdog timing starts only once a supply reset is inactive.
// - Any strobe edge before expiry restarts timing from zero.
// - On expiry the watchdog output pulses low for at least 100 us.
// - Watchdog output is open drain, sinking only.
// - No means of disabling the watchdog exists.
// - Master reset held 20 us forces resets and alarms; delay on release.
// - Supply reset stays active for the selected delay after recovery.
`default_nettype none
module svwd_top
  import svwd_pkg::*;
#(
  parameter int unsigned SHORT_CYC_P = SHORT_CYC,
  parameter int unsigned MID_CYC_P = MID_CYC,
  parameter int unsigned LONG_CYC_P = LONG_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output var logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog front end results and pins
  input wire logic supply_a_ok_i,
  input wire logic supply_b_ok_i,
  input wire logic main_above_1v5_i,
  input wire logic sense_input_one_i,
  input wire logic sense_input_two_i,
  input wire logic master_manual_reset_in_n_i,
  input wire logic [1:0] supply_manual_reset_in_n_i,
  input wire logic watchdog_kick_in_i,
  input wire logic [1:0] watchdog_period_select_i,
  input wire logic [1:0] delay_select_i,
  // Open-drain outputs, level is always low, enable sinks
  output logic last_reset_source_flag_o,
  output var logic last_reset_source_flag_oe_o,
  output logic sense_alarm_one_out_o,
  output var logic sense_alarm_one_out_oe_o,
  output logic sense_alarm_two_out_o,
  output var logic sense_alarm_two_out_oe_o,
  output logic watchdog_alarm_out_o,
  output var logic watchdog_alarm_out_oe_o,
  output logic [1:0] supply_reset_o,
  output var logic [1:0] supply_reset_oe_o
);
  localparam int unsigned NPIN = 13;
  // Idle levels: supplies low, buttons released, strobe low
  localparam logic [NPIN-1:0] PIN_INIT = 13'h00E0;

  logic [NPIN-1:0] pins_s;
  logic ok_a;
  logic ok_b;
  logic above_1v5;
  logic below_one;
  logic below_two;
  logic master_n;
  logic [1:0] supply_pb_n;
  logic [2:0] btn_n;
  logic kick_s;
  logic [1:0] wd_sel_raw;
  logic [1:0] td_sel_raw;
  logic hold_all;
  logic [SMALL_W-1:0] deb_r [0:2];
  logic [2:0] held_r;
  logic master_held;
  logic [1:0] rst_cond;
  logic [CNT_W-1:0] rst_cnt_r [0:1];
  logic [1:0] supply_rst_r;
  logic [1:0] wd_sel_r;
  logic [1:0] td_sel_r;
  logic straps_r;
  logic flag_low_r;
  logic alarm_one;
  logic alarm_two;
  logic alarm_one_d_r;
  logic alarm_two_d_r;
  svwd_wd_state_t wd_state_r;
  logic [CNT_W-1:0] wd_cnt_r;
  logic kick_d_r;
  logic kick_edge;
  logic wd_run;
  logic wd_expire;
  logic [EV_W-1:0] event_r;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  svwd_status_t status;
  logic bus_req;
  logic wr_event;

  // Pick a period count from a three-level strap
  function automatic logic [CNT_W-1:0] sel_cycles(input logic [1:0] code);
    logic [CNT_W-1:0] n;
    n = CNT_W'(SHORT_CYC_P);
    unique case (code)
      SEL_FLOAT: n = CNT_W'(MID_CYC_P);
      SEL_SUPPLY: n = CNT_W'(LONG_CYC_P);
      default: n = CNT_W'(SHORT_CYC_P);
    endcase
    return n;
  endfunction

  // All pin inputs cross in through one synchroniser
  svwd_sync #(
    .W(NPIN),
    .INIT(PIN_INIT)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({supply_a_ok_i, supply_b_ok_i, main_above_1v5_i,
            sense_input_one_i, sense_input_two_i,
            master_manual_reset_in_n_i, supply_manual_reset_in_n_i,
            watchdog_kick_in_i, watchdog_period_select_i,
            delay_select_i}),
    .value_o(pins_s)
  );

  assign {ok_a, ok_b, above_1v5, below_one, below_two, master_n,
          supply_pb_n, kick_s, wd_sel_raw, td_sel_raw} = pins_s;
  assign btn_n = {master_n, supply_pb_n};

  // Low supply: everything held active, logic runs on any rail >= 1.0V
  assign hold_all = ~above_1v5;

  // Straps captured once after reset; changing them later has no effect
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      straps_r <= 1'b0;
      wd_sel_r <= SEL_GROUND;
      td_sel_r <= SEL_GROUND;
    end
    else if (!straps_r && above_1v5)
    begin
      straps_r <= 1'b1;
      wd_sel_r <= wd_sel_raw;
      td_sel_r <= td_sel_raw;
    end
  end

  // Buttons count as pressed only after the debounce time
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (rst_i)
      begin
        deb_r[i] <= '0;
        held_r[i] <= 1'b0;
      end
      else if (btn_n[i])
      begin
        deb_r[i] <= '0;
        held_r[i] <= 1'b0;
      end
      else if (deb_r[i] == SMALL_W'(DEBOUNCE_CYC - 1))
        held_r[i] <= 1'b1;
      else
        deb_r[i] <= deb_r[i] + SMALL_W'(1);
    end
  end

  assign master_held = held_r[2];
  assign rst_cond[0] = ~ok_a | held_r[0] | master_held | hold_all;
  assign rst_cond[1] = ~ok_b | held_r[1] | master_held | hold_all;

  // Supply resets: active while the cause lasts, then the delay
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (rst_i || rst_cond[i])
      begin
        supply_rst_r[i] <= 1'b1;
        rst_cnt_r[i] <= '0;
      end
      else if (supply_rst_r[i])
      begin
        if (rst_cnt_r[i] >= sel_cycles(td_sel_r) - CNT_W'(1))
          supply_rst_r[i] <= 1'b0;
        else
          rst_cnt_r[i] <= rst_cnt_r[i] + CNT_W'(1);
      end
    end
  end

  // Master press wins over any other source in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_low_r <= 1'b0;
    else if (master_held)
      flag_low_r <= 1'b1;
    else if (~ok_a | ~ok_b | held_r[0] | held_r[1])
      flag_low_r <= 1'b0;
  end

  // Sense alarms; master press and low supply force them
  svwd_alarm u_alarm_one (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .below_i(below_one),
    .force_i(master_held | hold_all),
    .alarm_o(alarm_one)
  );

  svwd_alarm u_alarm_two (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .below_i(below_two),
    .force_i(master_held | hold_all),
    .alarm_o(alarm_two)
  );

  // Strobe edge of either polarity restarts the count
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      kick_d_r <= 1'b0;
    else
      kick_d_r <= kick_s;
  end

  assign kick_edge = kick_s ^ kick_d_r;
  assign wd_run = ~&supply_rst_r;
  assign wd_expire = (wd_state_r == WD_COUNT) && !kick_edge &&
    (wd_cnt_r >= sel_cycles(wd_sel_r) - CNT_W'(1));

  // Watchdog has no enable; only both supply resets held stop it and clear its count
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wd_state_r <= WD_IDLE;
      wd_cnt_r <= '0;
    end
    else
    begin
      unique case (wd_state_r)
        WD_IDLE:
        begin
          wd_cnt_r <= '0;
          if (wd_run)
            wd_state_r <= WD_COUNT;
        end
        WD_COUNT:
        begin
          if (!wd_run)
            wd_state_r <= WD_IDLE;
          else if (kick_edge)
            wd_cnt_r <= '0;
          else if (wd_expire)
          begin
            wd_state_r <= WD_PULSE;
            wd_cnt_r <= '0;
          end
          else
            wd_cnt_r <= wd_cnt_r + CNT_W'(1);
        end
        WD_PULSE:
        begin
          if (wd_cnt_r >= CNT_W'(WD_PULSE_CYC - 1))
          begin
            wd_state_r <= WD_COUNT;
            wd_cnt_r <= '0;
          end
          else
            wd_cnt_r <= wd_cnt_r + CNT_W'(1);
        end
        default:
        begin
          wd_state_r <= WD_IDLE;
          wd_cnt_r <= '0;
        end
      endcase
    end
  end

  // Open-drain drive: level fixed low, enable means sinking
  assign last_reset_source_flag_o = 1'b0;
  assign sense_alarm_one_out_o = 1'b0;
  assign sense_alarm_two_out_o = 1'b0;
  assign watchdog_alarm_out_o = 1'b0;
  assign supply_reset_o = 2'b00;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      last_reset_source_flag_oe_o <= 1'b1;
      sense_alarm_one_out_oe_o <= 1'b1;
      sense_alarm_two_out_oe_o <= 1'b1;
      watchdog_alarm_out_oe_o <= 1'b1;
      supply_reset_oe_o <= 2'b11;
    end
    else
    begin
      last_reset_source_flag_oe_o <= flag_low_r | hold_all;
      sense_alarm_one_out_oe_o <= alarm_one;
      sense_alarm_two_out_oe_o <= alarm_two;
      watchdog_alarm_out_oe_o <= (wd_state_r == WD_PULSE) |
        hold_all;
      supply_reset_oe_o <= supply_rst_r;
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      alarm_one_d_r <= 1'b1;
      alarm_two_d_r <= 1'b1;
    end
    else
    begin
      alarm_one_d_r <= alarm_one;
      alarm_two_d_r <= alarm_two;
    end
  end

  assign ev_set[EV_MASTER] = master_held & ~flag_low_r;
  assign ev_set[EV_ALARM1] = alarm_one & ~alarm_one_d_r;
  assign ev_set[EV_ALARM2] = alarm_two & ~alarm_two_d_r;
  assign ev_set[EV_WDOG] = wd_expire;
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_event = bus_req & wb_we_i & wb_sel_i[0] &
    (wb_adr_i == ADDR_EVENT);
  assign ev_clr = wr_event ? wb_dat_i[EV_W-1:0] : EV_RESET;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      event_r <= EV_RESET;
    else
      event_r <= (event_r & ~ev_clr) | ev_set;
  end

  assign status = '{
    wd_select: wd_sel_r,
    hold_all: hold_all,
    supply_rst_b: supply_rst_r[1],
    supply_rst_a: supply_rst_r[0],
    wd_pulse: wd_state_r == WD_PULSE,
    alarm_two: alarm_two,
    alarm_one: alarm_one,
    flag_low: flag_low_r
  };

  // Bus answers one cycle after the request; unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= '0;
      if (bus_req && !wb_we_i)
      begin
        unique case (wb_adr_i)
          ADDR_STATUS: wb_dat_o <= 32'(status);
          ADDR_EVENT: wb_dat_o <= 32'(event_r);
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/svwd_asserts.sv ----
// Checker for the supervisor event logic, bound to the top module
`default_nettype none
module svwd_asserts
  import svwd_pkg::*;
#(
  parameter int unsigned SHORT_CYC_P = 100,
  parameter int unsigned MID_CYC_P = 200,
  parameter int unsigned LONG_CYC_P = 400
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic main_above_1v5_i,
  input wire logic sense_input_one_i,
  input wire logic master_manual_reset_in_n_i,
  input wire logic watchdog_kick_in_i,
  input wire logic [1:0] watchdog_period_select_i,
  input wire logic last_reset_source_flag_o,
  input wire logic last_reset_source_flag_oe_o,
  input wire logic sense_alarm_one_out_oe_o,
  input wire logic sense_alarm_two_out_oe_o,
  input wire logic watchdog_alarm_out_o,
  input wire logic watchdog_alarm_out_oe_o,
  input wire logic [1:0] supply_reset_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [15:0] up_r, mst_r, blw_r, idle_r, wd_r, al_r;
  logic kick_r;
  int unsigned per;
  wire quiet = up_r == 16'h000f;
  // Settle time after reset or a low supply; edges there are not judged
  always_ff @(posedge clk_i)
    if (rst_i || !main_above_1v5_i) up_r <= '0;
    else if (!quiet) up_r <= up_r + 16'h0001;
  // Run lengths of raw input and output levels
  always_ff @(posedge clk_i)
  begin
    mst_r <= (rst_i || master_manual_reset_in_n_i) ? '0 : mst_r + 16'h0001;
    blw_r <= (rst_i || !sense_input_one_i) ? '0 : blw_r + 16'h0001;
    wd_r <= (!rst_i && watchdog_alarm_out_oe_o) ? wd_r + 16'h0001 : '0;
    al_r <= (!rst_i && sense_alarm_one_out_oe_o) ? al_r + 16'h0001 : '0;
    kick_r <= watchdog_kick_in_i;
    idle_r <= (rst_i || watchdog_kick_in_i != kick_r) ? '0 : idle_r + 16'h0001;
  end
  // Timeout in force; strap is only changed while in reset
  always_comb
    case (watchdog_period_select_i)
      SEL_FLOAT: per = MID_CYC_P;
      SEL_SUPPLY: per = LONG_CYC_P;
      default: per = SHORT_CYC_P;
    endcase
  AST_OPEN_DRAIN: assert property (
    !last_reset_source_flag_o && !watchdog_alarm_out_o)
    else $error("open-drain pin driven high");
  AST_MASTER_HOLD: assert property (
    mst_r > 16'd410 |-> last_reset_source_flag_oe_o &&
    sense_alarm_one_out_oe_o && sense_alarm_two_out_oe_o &&
    &supply_reset_oe_o)
    else $error("master hold not forcing outputs");
  AST_FLAG_SET: assert property (
    quiet && $rose(last_reset_source_flag_oe_o) |-> mst_r >= 16'd400)
    else $error("flag set without master hold");
  AST_HOLD_ALL: assert property (
    !main_above_1v5_i [*7] |-> last_reset_source_flag_oe_o &&
    sense_alarm_one_out_oe_o && sense_alarm_two_out_oe_o &&
    watchdog_alarm_out_oe_o && &supply_reset_oe_o)
    else $error("low supply not holding outputs");
  AST_ALARM_BELOW: assert property (
    blw_r >= 16'd50 |-> sense_alarm_one_out_oe_o)
    else $error("alarm released while below");
  AST_ALARM_FILTER: assert property (
    quiet && mst_r == '0 && $rose(sense_alarm_one_out_oe_o) |->
    blw_r >= 16'd40)
    else $error("alarm on short dip");
  AST_ALARM_MIN: assert property (
    quiet && $fell(sense_alarm_one_out_oe_o) |-> al_r >= ALARM_MIN_CYC)
    else $error("alarm pulse too short");
  AST_WD_PULSE: assert property (
    quiet && $fell(watchdog_alarm_out_oe_o) |-> wd_r >= WD_PULSE_CYC)
    else $error("watchdog pulse too short");
  AST_WD_TIMEOUT: assert property (
    quiet && $rose(watchdog_alarm_out_oe_o) |-> idle_r >= per - 1)
    else $error("watchdog expired early");
  cover property (quiet && $rose(watchdog_alarm_out_oe_o));
  cover property (quiet && $rose(sense_alarm_one_out_oe_o));
  cover property (mst_r == 16'd420);
endmodule
bind svwd_top svwd_asserts #(.SHORT_CYC_P(SHORT_CYC_P), .MID_CYC_P(MID_CYC_P),
  .LONG_CYC_P(LONG_CYC_P)) i_svwd_asserts (.clk_i(clk_i), .rst_i(rst_i),
  .main_above_1v5_i(main_above_1v5_i), .sense_input_one_i(sense_input_one_i),
  .master_manual_reset_in_n_i(master_manual_reset_in_n_i),
  .watchdog_kick_in_i(watchdog_kick_in_i),
  .watchdog_period_select_i(watchdog_period_select_i),
  .last_reset_source_flag_o(last_reset_source_flag_o),
  .last_reset_source_flag_oe_o(last_reset_source_flag_oe_o),
  .sense_alarm_one_out_oe_o(sense_alarm_one_out_oe_o),
  .sense_alarm_two_out_oe_o(sense_alarm_two_out_oe_o),
  .watchdog_alarm_out_o(watchdog_alarm_out_o),
  .watchdog_alarm_out_oe_o(watchdog_alarm_out_oe_o),
  .supply_reset_oe_o(supply_reset_oe_o));
`default_nettype wire

// ---- tb/svwd_host.sv ----
// Host model: toggles the watchdog strobe and counts status pulses
`default_nettype none
module svwd_host
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] ival_i,
  input wire logic wd_pin_i,
  output var logic kick_o,
  output var logic [7:0] pulses_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt_r;
  logic pin_r;
  // Strobe every ival_i cycles; zero models a hung host
  always_ff @(posedge clk_i)
  begin
    if (rst_i || ival_i == 16'h0000)
      cnt_r <= 16'h0000;
    else if (cnt_r + 16'h0001 >= ival_i)
      cnt_r <= 16'h0000;
    else
      cnt_r <= cnt_r + 16'h0001;
    if (rst_i)
      kick_o <= 1'b0;
    else if (ival_i != 16'h0000 && cnt_r + 16'h0001 >= ival_i)
      kick_o <= ~kick_o;
  end
  // Falling edges of the pulled-up status pin
  always_ff @(posedge clk_i)
  begin
    pin_r <= wd_pin_i;
    if (rst_i)
      pulses_o <= 8'h00;
    else if (pin_r && !wd_pin_i)
      pulses_o <= pulses_o + 8'h01;
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the supervisor event logic
`default_nettype none
module testbench
  import svwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack, hi = 1'b1;
  logic mn = 1'b1, s1 = 1'b0, s2 = 1'b0, kick, fo, foe, a1o, a1e, a2o, a2e;
  logic wo, woe;
  logic [1:0] bn = 2'h3, ws = 2'h0, ro, roe, ok = 2'h3;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00, np;
  logic [15:0] iv = 16'h0000;
  logic [31:0] wd = 32'h0, rd;
  logic [31:0] q[$];
  int n_mismatch = 0, compares = 0, seed = 32'hcff2, n, k, per;
  // Pin levels with pull-ups: bit 0 flag, 1..2 alarms, 3 watchdog, 5:4 resets
  wire [5:0] pin = ~{roe, woe, a2e, a1e, foe} | {ro, wo, a2o, a1o, fo};
  svwd_top #(.SHORT_CYC_P(100), .MID_CYC_P(200), .LONG_CYC_P(400))
    i_svwd_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
    .wb_ack_o(ack), .supply_a_ok_i(ok[0]), .supply_b_ok_i(ok[1]),
    .main_above_1v5_i(hi), .sense_input_one_i(s1), .sense_input_two_i(s2),
    .master_manual_reset_in_n_i(mn), .supply_manual_reset_in_n_i(bn),
    .watchdog_kick_in_i(kick), .watchdog_period_select_i(ws),
    .delay_select_i(2'h1), .last_reset_source_flag_o(fo),
    .last_reset_source_flag_oe_o(foe), .sense_alarm_one_out_o(a1o),
    .sense_alarm_one_out_oe_o(a1e), .sense_alarm_two_out_o(a2o),
    .sense_alarm_two_out_oe_o(a2e), .watchdog_alarm_out_o(wo),
    .watchdog_alarm_out_oe_o(woe), .supply_reset_o(ro),
    .supply_reset_oe_o(roe));
  svwd_host i_svwd_host (.clk_i(clk_i), .rst_i(rst_i), .ival_i(iv),
    .wd_pin_i(pin[3]), .kick_o(kick), .pulses_o(np));
  // 20 MHz clock
  initial forever #25 clk_i = ~clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic tmo;
    n_mismatch++;
    end_sim;
  endtask
  // Classic cycle; a read notes its expected word for the monitor
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    cyc <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wd <= d;
    if (!w) q.push_back(d);
    c = 0;
    do
    begin
      @(posedge clk_i);
      c++;
    end
    while (ack !== 1'b1 && c < 20);
    cyc <= 1'b0;
    if (c == 20) tmo;
    @(posedge clk_i);
  endtask
  // Bounded wait for one pin level, cycles waited in n
  task automatic wt(input int i, input logic v, input int lim);
    n = 0;
    while (pin[i] !== v && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim) tmo;
  endtask
  task automatic rs(input logic [1:0] s);
    ws <= s;
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wt(4, 1'b1, 2000);
    check(np, 8'h00);
  endtask
  // Read data taken at the ack edge against the oldest note
  always @(posedge clk_i)
    if (ack === 1'b1 && !we)
    begin
      if (q.size() == 0) tmo;
      check(rd, q.pop_front());
    end
  initial
  begin
    for (int s = 0; s < 3; s++)
    begin
      per = 100 << s;
      iv <= 16'h0000;
      rs(s[1:0]);
      bus(1'b0, ADDR_STATUS, {23'h0, s[1:0], 7'h00});
      k = per / 4 + $unsigned($random(seed)) % (per / 4);
      iv <= k[15:0];
      repeat (3 * per) @(posedge clk_i);
      check(pin[3], 1'b1);
      iv <= 16'h0000;
      wt(3, 1'b0, 2 * per);
      check(n <= per + 10 && n + k + 1 >= per, 1'b1);
      wt(3, 1'b1, 3000);
      check(n >= WD_PULSE_CYC, 1'b1);
      iv <= k[15:0];
      bus(1'b0, ADDR_EVENT, 32'h8);
      bus(1'b1, ADDR_EVENT, 32'h8);
      bus(1'b0, ADDR_EVENT, 32'h0);
    end
    // Unmapped read and a write to the read-only word
    bus(1'b1, ADDR_STATUS, 32'hffff_ffff);
    bus(1'b0, ADDR_STATUS, {23'h0, 2'h2, 7'h00});
    bus(1'b0, 8'h08, 32'h0);
    // Short dips then a long one on each sense input
    for (int i = 1; i < 3; i++)
    begin
      repeat (4)
      begin
        k = 1 + $unsigned($random(seed)) % 30;
        {s2, s1} <= i[1:0];
        repeat (k) @(posedge clk_i);
        {s2, s1} <= 2'h0;
        repeat (60) @(posedge clk_i);
        check(pin[i], 1'b1);
      end
      {s2, s1} <= i[1:0];
      wt(i, 1'b0, 100);
      check(n >= 40 && n <= 48, 1'b1);
      repeat (100) @(posedge clk_i);
      check(pin[i], 1'b0);
      {s2, s1} <= 2'h0;
      wt(i, 1'b1, 1000);
      check(n >= ALARM_MIN_CYC, 1'b1);
      bus(1'b0, ADDR_EVENT, 32'h1 << i);
      bus(1'b1, ADDR_EVENT, 32'hf);
    end
    // Master hold, release, then a per-supply button clears the flag
    mn <= 1'b0;
    repeat (450) @(posedge clk_i);
    check(pin, 6'h08);
    mn <= 1'b1;
    repeat (500) @(posedge clk_i);
    check(pin, 6'h3e);
    bn <= 2'h2;
    repeat (450) @(posedge clk_i);
    bn <= 2'h3;
    check(pin[0], 1'b1);
    mn <= 1'b0;
    repeat (100) @(posedge clk_i);
    mn <= 1'b1;
    repeat (10) @(posedge clk_i);
    check(pin[0], 1'b1);
    // Master press again, then a supply drop releases the flag
    mn <= 1'b0;
    repeat (450) @(posedge clk_i);
    mn <= 1'b1;
    check(pin[0], 1'b0);
    ok <= 2'h1;
    repeat (20) @(posedge clk_i);
    ok <= 2'h3;
    check(pin[0], 1'b1);
    // Supplies below the accurate level hold every output
    hi <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(pin, 6'h00);
    hi <= 1'b1;
    end_sim;
  end
endmodule
`default_nettype wire
